/* File: hdl/diag_clock_pkg.sv */
// Constants shared by the offset, diagnostic and clock register logic
`default_nettype none
package diag_clock_pkg;
  // ==========================================================================
  // Register byte addresses (low byte of each 16-bit word)
  localparam logic [6:0] ADDR_DIAG     = 7'h1a;
  localparam logic [6:0] ADDR_CHECKSUM = 7'h1e;
  localparam logic [6:0] ADDR_X_OFF    = 7'h20;
  localparam logic [6:0] ADDR_Y_OFF    = 7'h22;
  localparam logic [6:0] ADDR_Z_OFF    = 7'h24;
  localparam logic [6:0] ADDR_TIME     = 7'h2e;
  localparam logic [6:0] ADDR_DATE     = 7'h30;
  localparam logic [6:0] ADDR_YEAR     = 7'h32;
  localparam logic [6:0] ADDR_WAKE_T   = 7'h34;
  localparam logic [6:0] ADDR_WAKE_D   = 7'h36;
  // ==========================================================================
  // Implemented bits of each register
  localparam logic [15:0] MASK_OFF    = 16'h03ff;
  localparam logic [15:0] MASK_DIAG   = 16'h03ff;
  localparam logic [15:0] MASK_TIME   = 16'h3f7f;
  localparam logic [15:0] MASK_DATE   = 16'h1f3f;
  localparam logic [15:0] MASK_YEAR   = 16'h00ff;
  localparam logic [15:0] MASK_WAKE_T = 16'hbf7f;
  localparam logic [15:0] MASK_WAKE_D = 16'h3f3f;
  localparam int          OFF_WIDTH   = 10;
  // ==========================================================================
  // Diagnostic flag positions and the wake enable bit
  localparam int DIAG_SUPPLY_LOW  = 0;
  localparam int DIAG_SUPPLY_HIGH = 1;
  localparam int DIAG_FLASH_FAIL  = 2;
  localparam int DIAG_SPI_FAIL    = 3;
  localparam int DIAG_POST_BUSY   = 4;
  localparam int DIAG_POST_FAIL   = 5;
  localparam int DIAG_CHECKSUM    = 6;
  localparam int DIAG_BUF_FULL    = 7;
  localparam int DIAG_ALARM1      = 8;
  localparam int DIAG_ALARM2      = 9;
  localparam int WAKE_ENABLE_BIT  = 15;
  // ==========================================================================
  // Reset values
  localparam logic [15:0] RESET_REG = 16'h0000;
  // ==========================================================================
  // Timing: one real-time-clock minute at the 40 MHz reference
  localparam longint unsigned CLK_HZ        = 64'd40000000;
  localparam longint unsigned MINUTE_S      = 64'd60;
  localparam longint unsigned MINUTE_CYCLES = MINUTE_S * CLK_HZ;
endpackage : diag_clock_pkg
`default_nettype wire

/* File: hdl/diag_offset_clock_registers.sv */
// Offset, diagnostic, clock and checksum registers behind the serial port
// Function
// - Offsets are 10-bit two's complement, upper bits unused
// - Offsets add to each axis output
// - Error flags read one while condition present
// - Reading diagnostic register clears all flags
// - Supply flags return at next sample cycle
// - Bit 1 supply high, bit 0 low
// - Bits 9 and 8 report alarms
// - Bit 7 flags capture buffer full
// - Bit 6 flags program checksum mismatch
// - Bit 5 self-test fail, bit 4 busy
// - Bit 3 flags clock count not multiple 16
// - Bit 2 flags flash update failure
// - Time register holds BCD hours and minutes
// - Date and year registers hold BCD values
// - Enabled wake time ends standby at match
// - Checksum register reads the program memory sum
`default_nettype none
module diag_offset_clock_registers
  import diag_clock_pkg::*;
#(
  parameter int          ACC_WIDTH     = 14,
  parameter logic [31:0] MINUTE_CYCLES_P = 32'(MINUTE_CYCLES)
) (
  input  wire logic                        ref_clk,
  input  wire logic                        reset,
  input  wire logic                        sclk,
  input  wire logic                        csN,
  input  wire logic                        din,
  output logic                             dout,
  output logic                             doutEn,
  input  wire logic                        sampleStrobe,
  input  wire logic signed [ACC_WIDTH-1:0] xRaw,
  input  wire logic signed [ACC_WIDTH-1:0] yRaw,
  input  wire logic signed [ACC_WIDTH-1:0] zRaw,
  output logic signed [ACC_WIDTH-1:0]      xOut,
  output logic signed [ACC_WIDTH-1:0]      yOut,
  output logic signed [ACC_WIDTH-1:0]      zOut,
  output logic                             outValid,
  input  wire logic                        supplyHigh,
  input  wire logic                        supplyLow,
  input  wire logic                        flashFail,
  input  wire logic                        selftestBusy,
  input  wire logic                        selftestFail,
  input  wire logic                        checksumMismatch,
  input  wire logic                        bufferFull,
  input  wire logic                        alarm1,
  input  wire logic                        alarm2,
  input  wire logic [15:0]                 checksumValue,
  input  wire logic                        inStandby,
  output logic                             wakeRequest,
  output logic [15:0]                      timestamp
);

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  // ==========================================================================
  // Helpers
  function automatic logic [15:0] writeByte(input logic [15:0] old, input logic lane,
                                            input logic [7:0] data, input logic [15:0] mask);
    logic [15:0] w;
    w = lane ? {data, old[7:0]} : {old[15:8], data};
    return w & mask;
  endfunction : writeByte

  function automatic logic signed [ACC_WIDTH-1:0] addOffset(
      input logic signed [ACC_WIDTH-1:0] raw, input logic [15:0] off);
    logic signed [ACC_WIDTH-1:0] ext;
    ext = ACC_WIDTH'(signed'(off[OFF_WIDTH-1:0]));
    return ACC_WIDTH'(raw + ext);
  endfunction : addOffset

  // Two-digit BCD step; returns wrapped value and carry at the limit
  function automatic logic [8:0] bcdStep(input logic [7:0] v, input logic [7:0] last);
    logic [7:0] n;
    n = 8'h00;
    if (v == last) begin
      return {1'b1, 8'h00};
    end
    if (v[3:0] == 4'h9) begin
      n = {4'(v[7:4] + 4'h1), 4'h0};
    end else begin
      n = {v[7:4], 4'(v[3:0] + 4'h1)};
    end
    return {1'b0, n};
  endfunction : bcdStep

  // ==========================================================================
  // Pin synchronisers; stage 1 feeds stage 2 only
  logic sclkS1, sclkS2, sclkS3;
  logic csS1, csS2, csS3;
  logic dinS1, dinS2;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sclkS1 <= 1'b1;
      sclkS2 <= 1'b1;
      sclkS3 <= 1'b1;
      csS1   <= 1'b1;
      csS2   <= 1'b1;
      csS3   <= 1'b1;
      dinS1  <= 1'b0;
      dinS2  <= 1'b0;
    end else begin
      sclkS1 <= sclk;
      sclkS2 <= sclkS1;
      sclkS3 <= sclkS2;
      csS1   <= csN;
      csS2   <= csS1;
      csS3   <= csS2;
      dinS1  <= din;
      dinS2  <= dinS1;
    end
  end

  logic sclkRise, sclkFall, csRise;
  assign sclkRise = sclkS2 & ~sclkS3 & ~csS2;
  assign sclkFall = ~sclkS2 & sclkS3 & ~csS2;
  assign csRise   = csS2 & ~csS3;

  // ==========================================================================
  // Serial frame: bit 15 write, bits 14:8 address, bits 7:0 write data
  logic [3:0]  bitCnt_reg;
  logic [15:0] rxShift_reg;
  logic [15:0] txShift_reg;
  logic        txDiag_reg;
  logic [15:0] rxWord;
  logic        frameDone;
  logic        spiErr;
  logic        clearPulse;
  logic [15:0] readWord;

  assign rxWord     = {rxShift_reg[14:0], dinS2};
  assign frameDone  = sclkRise && (bitCnt_reg == 4'hf);
  assign spiErr     = csRise && (bitCnt_reg != 4'h0);
  // Flags are cleared only once the frame that carried them out has ended
  assign clearPulse = frameDone && txDiag_reg;

  always_ff @(posedge ref_clk) begin
    if (reset || csRise) begin
      bitCnt_reg <= 4'h0;
    end else if (sclkRise) begin
      bitCnt_reg <= 4'(bitCnt_reg + 4'h1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rxShift_reg <= RESET_REG;
    end else if (sclkRise) begin
      rxShift_reg <= rxWord;
    end
  end

  // Read answers go out in the following frame, MSB first, changed on falling edges
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      txShift_reg <= RESET_REG;
      txDiag_reg  <= 1'b0;
    end else if (frameDone) begin
      txShift_reg <= rxWord[15] ? RESET_REG : readWord;
      txDiag_reg  <= !rxWord[15] && (rxWord[14:9] == ADDR_DIAG[6:1]);
    end else if (sclkFall && bitCnt_reg != 4'h0) begin
      txShift_reg <= {txShift_reg[14:0], 1'b0};
    end
  end

  assign dout   = txShift_reg[15];
  assign doutEn = ~csS2;

  // ==========================================================================
  // Writable registers
  logic [15:0] xOff_reg, yOff_reg, zOff_reg;
  logic [15:0] time_reg, date_reg, year_reg, wakeTime_reg, wakeDate_reg;
  logic [15:0] diag_reg;
  logic        wrEn;
  logic [6:0]  wrWord;
  logic [7:0]  wrData;
  logic        wrLane;

  assign wrEn   = frameDone && rxWord[15];
  assign wrWord = {rxWord[14:9], 1'b0};
  assign wrLane = rxWord[8];
  assign wrData = rxWord[7:0];

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      xOff_reg     <= RESET_REG;
      yOff_reg     <= RESET_REG;
      zOff_reg     <= RESET_REG;
      date_reg     <= RESET_REG;
      year_reg     <= RESET_REG;
      wakeTime_reg <= RESET_REG;
      wakeDate_reg <= RESET_REG;
    end else if (wrEn) begin
      case (wrWord)
        ADDR_X_OFF:  xOff_reg     <= writeByte(xOff_reg, wrLane, wrData, MASK_OFF);
        ADDR_Y_OFF:  yOff_reg     <= writeByte(yOff_reg, wrLane, wrData, MASK_OFF);
        ADDR_Z_OFF:  zOff_reg     <= writeByte(zOff_reg, wrLane, wrData, MASK_OFF);
        ADDR_DATE:   date_reg     <= writeByte(date_reg, wrLane, wrData, MASK_DATE);
        ADDR_YEAR:   year_reg     <= writeByte(year_reg, wrLane, wrData, MASK_YEAR);
        ADDR_WAKE_T: wakeTime_reg <= writeByte(wakeTime_reg, wrLane, wrData, MASK_WAKE_T);
        ADDR_WAKE_D: wakeDate_reg <= writeByte(wakeDate_reg, wrLane, wrData, MASK_WAKE_D);
        default: begin
        end
      endcase
    end
  end

  // ==========================================================================
  // Time of day: a host write wins over the minute tick
  logic [31:0] minuteCnt_reg;
  logic        minuteTick;
  logic [8:0]  minStep, hourStep;

  assign minuteTick = (minuteCnt_reg == MINUTE_CYCLES_P - 32'h1);
  assign minStep    = bcdStep({1'b0, time_reg[6:0]}, 8'h59);
  assign hourStep   = bcdStep({2'b00, time_reg[13:8]}, 8'h23);

  always_ff @(posedge ref_clk) begin
    if (reset || minuteTick) begin
      minuteCnt_reg <= 32'h0;
    end else begin
      minuteCnt_reg <= minuteCnt_reg + 32'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      time_reg <= RESET_REG;
    end else if (wrEn && wrWord == ADDR_TIME) begin
      time_reg <= writeByte(time_reg, wrLane, wrData, MASK_TIME);
    end else if (minuteTick) begin
      time_reg[6:0] <= minStep[6:0];
      if (minStep[8]) begin
        time_reg[13:8] <= hourStep[5:0];
      end
    end
  end

  assign timestamp = time_reg;

  // ==========================================================================
  // Diagnostic flags: a set in the clearing cycle survives
  logic [15:0] diagSet;

  always_comb begin
    diagSet                   = 16'h0000;
    diagSet[DIAG_SUPPLY_LOW]  = sampleStrobe && supplyLow;
    diagSet[DIAG_SUPPLY_HIGH] = sampleStrobe && supplyHigh;
    diagSet[DIAG_FLASH_FAIL]  = flashFail;
    diagSet[DIAG_SPI_FAIL]    = spiErr;
    diagSet[DIAG_POST_BUSY]   = selftestBusy;
    diagSet[DIAG_POST_FAIL]   = selftestFail;
    diagSet[DIAG_CHECKSUM]    = checksumMismatch;
    diagSet[DIAG_BUF_FULL]    = bufferFull;
    diagSet[DIAG_ALARM1]      = alarm1;
    diagSet[DIAG_ALARM2]      = alarm2;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      diag_reg <= RESET_REG;
    end else begin
      diag_reg <= ((clearPulse ? 16'h0000 : diag_reg) | diagSet) & MASK_DIAG;
    end
  end

  // ==========================================================================
  // Read mux; unmapped addresses read zero
  always_comb begin
    case ({rxWord[14:9], 1'b0})
      ADDR_DIAG:     readWord = diag_reg;
      ADDR_CHECKSUM: readWord = checksumValue;
      ADDR_X_OFF:    readWord = xOff_reg;
      ADDR_Y_OFF:    readWord = yOff_reg;
      ADDR_Z_OFF:    readWord = zOff_reg;
      ADDR_TIME:     readWord = time_reg;
      ADDR_DATE:     readWord = date_reg;
      ADDR_YEAR:     readWord = year_reg;
      ADDR_WAKE_T:   readWord = wakeTime_reg;
      ADDR_WAKE_D:   readWord = wakeDate_reg;
      default:       readWord = 16'h0000;
    endcase
  end

  // ==========================================================================
  // Offset correction; the sum wraps, the sensor range leaves headroom
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      xOut     <= '0;
      yOut     <= '0;
      zOut     <= '0;
      outValid <= 1'b0;
    end else begin
      outValid <= sampleStrobe;
      if (sampleStrobe) begin
        xOut <= addOffset(xRaw, xOff_reg);
        yOut <= addOffset(yRaw, yOff_reg);
        zOut <= addOffset(zRaw, zOff_reg);
      end
    end
  end

  // ==========================================================================
  // Wake from standby at the programmed time and date
  logic wakeMatch;
  assign wakeMatch = inStandby && wakeTime_reg[WAKE_ENABLE_BIT]
                     && (wakeTime_reg[13:0] == time_reg[13:0])
                     && (wakeDate_reg[12:0] == date_reg[12:0]);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wakeRequest <= 1'b0;
    end else begin
      wakeRequest <= wakeMatch;
    end
  end

  // ==========================================================================
  // Checks
  AST_OFFSET_ADD: assert property (
    sampleStrobe |=> xOut == addOffset($past(xRaw), $past(xOff_reg)) && outValid)
    else $error("x output lacks its offset");
  AST_OFF_UNUSED: assert property (
    xOff_reg[15:10] == 6'h00 && yOff_reg[15:10] == 6'h00 && zOff_reg[15:10] == 6'h00)
    else $error("offset upper bits not zero");
  AST_SUPPLY_AGAIN: assert property (
    sampleStrobe && supplyHigh |=> diag_reg[DIAG_SUPPLY_HIGH])
    else $error("supply high flag not set at sample");
  AST_SUPPLY_LOW: assert property (
    sampleStrobe && supplyLow |=> diag_reg[DIAG_SUPPLY_LOW])
    else $error("supply low flag not set at sample");
  AST_CLEAR_ALL: assert property (
    clearPulse && diagSet == 16'h0000 |=> diag_reg == 16'h0000)
    else $error("flags not cleared after read");
  AST_READ_OLD: assert property (
    frameDone && !rxWord[15] && rxWord[14:9] == ADDR_DIAG[6:1]
      |=> txShift_reg == $past(diag_reg)
          && diag_reg == (($past(clearPulse) ? 16'h0000 : $past(diag_reg)) | $past(diagSet)))
    else $error("diagnostic read not the held flags");
  AST_SPI_COUNT: assert property (
    csRise && bitCnt_reg != 4'h0 |=> diag_reg[DIAG_SPI_FAIL])
    else $error("bad clock count not flagged");
  AST_CHECKSUM: assert property (
    checksumMismatch ##1 !clearPulse |-> diag_reg[DIAG_CHECKSUM])
    else $error("checksum mismatch not flagged");
  AST_ALARMS: assert property (
    alarm1 && alarm2 |=> diag_reg[9:8] == 2'b11)
    else $error("alarm flags missing");
  AST_WAKE: assert property (
    wakeMatch |=> wakeRequest ##0 $past(wakeTime_reg[WAKE_ENABLE_BIT]))
    else $error("wake not raised at match");
  AST_NO_WAKE: assert property (
    !wakeTime_reg[WAKE_ENABLE_BIT] |=> !wakeRequest)
    else $error("wake raised while disabled");

endmodule : diag_offset_clock_registers
`default_nettype wire

/* File: tb/spi_host_model.sv */
// Host serial master model: mode 3, 16-bit frames, MSB first
`default_nettype none
module spi_host_model (
  input  wire logic ref_clk,
  output logic      sclk,
  output logic      csN,
  output logic      din,
  input  wire logic dout,
  input  wire logic doutEn
);
  timeunit 1ns;
  timeprecision 100ps;
  // Six reference cycles per phase leaves margin over the synchroniser delay
  localparam int HALF = 6;

  initial begin
    sclk = 1'b1;
    csN  = 1'b1;
    din  = 1'b0;
  end

  task automatic waitCycles(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask : waitCycles

  // ==========================================================================
  // One frame; nBits below 16 makes a short, faulty frame
  task automatic xfer(input logic [15:0] tx, input int nBits, output logic [15:0] rx);
    rx  = 16'h0000;
    csN = 1'b0;
    waitCycles(HALF);
    for (int i = 15; i > 15 - nBits; i--) begin
      sclk = 1'b0;
      din  = tx[i];
      waitCycles(HALF);
      sclk = 1'b1;
      // A deselected output reads as its inverse, so a missing enable shows up
      rx   = {rx[14:0], (doutEn === 1'b1) ? dout : ~dout};
      waitCycles(HALF);
    end
    csN = 1'b1;
    // Released line must not keep showing the last bit
    din = ~din;
    waitCycles(HALF);
  endtask : xfer
endmodule : spi_host_model
`default_nettype wire

/* File: tb/test_diag_offset_clock_registers.sv */
// Register-level testbench for the offset, diagnostic and clock block
`default_nettype none
module test_diag_offset_clock_registers;
  timeunit 1ns;
  timeprecision 100ps;
  import diag_clock_pkg::*;
  localparam int ACCW = 14;
  logic                   refClk = 1'b0;
  logic                   reset = 1'b1;
  logic                   sclk, csN, din, dout, doutEn, outValid, wakeRequest;
  logic                   sampleStrobe = 1'b0;
  logic                   inStandby = 1'b0;
  logic [9:0]             errIn = '0;
  logic [15:0]            checksumValue = 16'h5a3c;
  logic [15:0]            timestamp, rx;
  logic signed [ACCW-1:0] xRaw = '0, yRaw = '0, zRaw = '0, xOut, yOut, zOut;
  int                     fails = 0, checkCount = 0, cycles = 0;
  logic [6:0]  rwAddr [8] = '{ADDR_X_OFF, ADDR_Y_OFF, ADDR_Z_OFF, ADDR_TIME, ADDR_DATE,
                              ADDR_YEAR, ADDR_WAKE_T, ADDR_WAKE_D};
  logic [15:0] rwMask [8] = '{MASK_OFF, MASK_OFF, MASK_OFF, MASK_TIME, MASK_DATE,
                              MASK_YEAR, MASK_WAKE_T, MASK_WAKE_D};

  always #12.5 refClk = ~refClk;

  spi_host_model host_u (.ref_clk(refClk), .sclk(sclk), .csN(csN), .din(din), .dout(dout),
    .doutEn(doutEn));

  diag_offset_clock_registers #(.ACC_WIDTH(ACCW)) dut_u (
    .ref_clk(refClk), .reset(reset), .sclk(sclk), .csN(csN), .din(din), .dout(dout),
    .doutEn(doutEn), .sampleStrobe(sampleStrobe), .xRaw(xRaw), .yRaw(yRaw), .zRaw(zRaw),
    .xOut(xOut), .yOut(yOut), .zOut(zOut), .outValid(outValid),
    .supplyHigh(errIn[1]), .supplyLow(errIn[0]), .flashFail(errIn[2]),
    .selftestBusy(errIn[4]), .selftestFail(errIn[5]), .checksumMismatch(errIn[6]),
    .bufferFull(errIn[7]), .alarm1(errIn[8]), .alarm2(errIn[9]),
    .checksumValue(checksumValue), .inStandby(inStandby), .wakeRequest(wakeRequest),
    .timestamp(timestamp));

  // ==========================================================================
  // Helpers
  task automatic summarize();
    if (fails == 0 && checkCount > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize

  always @(posedge refClk) begin
    cycles++;
    if (cycles == 60000) begin
      fails++;
      summarize();
    end
  end

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    checkCount++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge refClk);
    #2;
  endtask : cyc

  // Byte lanes: lower byte first so an enable bit in the upper byte lands last
  task automatic wr(input logic [6:0] addr, input logic [15:0] word);
    host_u.xfer({1'b1, addr & 7'h7e, word[7:0]}, 16, rx);
    host_u.xfer({1'b1, addr | 7'h01, word[15:8]}, 16, rx);
  endtask : wr

  // Answer arrives in the following frame, which reads an unmapped place
  task automatic rd(input logic [6:0] addr, input logic [15:0] exp, input string name);
    host_u.xfer({1'b0, addr, 8'h00}, 16, rx);
    host_u.xfer(16'h0000, 16, rx);
    check(name, exp, rx);
  endtask : rd

  task automatic strobe();
    sampleStrobe = 1'b1;
    cyc(1);
    sampleStrobe = 1'b0;
    for (int i = 0; i < 3 && outValid !== 1'b1; i++) cyc(1);
  endtask : strobe

  function automatic logic signed [ACCW-1:0] addOff(input logic signed [ACCW-1:0] raw,
                                                    input logic [15:0] off);
    logic signed [9:0] o;
    o = off[9:0];
    return raw + ACCW'(o);
  endfunction : addOff

  // ==========================================================================
  // Main sequence
  initial begin
    cyc(12);
    reset = 1'b0;
    cyc(3);
    check("doutEn idle", 16'h0000, {15'h0000, doutEn});
    rd(ADDR_DIAG, 16'h0000, "diag reset");
    for (int i = 0; i < 8; i++) rd(rwAddr[i], 16'h0000, "reset value");
    for (int i = 0; i < 8; i++) begin
      wr(rwAddr[i], 16'hffff);
      rd(rwAddr[i], rwMask[i], "masked readback");
    end
    wr(ADDR_CHECKSUM, 16'h1111);
    rd(ADDR_CHECKSUM, 16'h5a3c, "checksum");
    rd(7'h7e, 16'h0000, "unmapped");
    // Offsets, with wrap at both ends of the output range
    wr(ADDR_X_OFF, 16'hfff6);
    wr(ADDR_Y_OFF, 16'h01ff);
    wr(ADDR_Z_OFF, 16'h0200);
    xRaw = 14'sd100;
    yRaw = 14'sh1fff;
    zRaw = 14'sh2000;
    strobe();
    check("outValid", 16'h0001, {15'h0000, outValid});
    check("xOut", 16'(addOff(xRaw, 16'hfff6)), 16'(xOut));
    check("yOut", 16'(addOff(yRaw, 16'h01ff)), 16'(yOut));
    check("zOut", 16'(addOff(zRaw, 16'h0200)), 16'(zOut));
    // Each flag alone, then cleared by the read that returned it
    for (int b = 0; b < 10; b++) begin
      errIn[b] = 1'b1;
      // Bit 3 has no input pin: a short frame raises it instead
      if (b == 3) host_u.xfer(16'h0000, 15, rx);
      else if (b < 2) strobe();
      else cyc(1);
      errIn[b] = 1'b0;
      rd(ADDR_DIAG, 16'h0001 << b, "diag flag");
      rd(ADDR_DIAG, 16'h0000, "diag cleared");
    end
    errIn[1] = 1'b1;
    strobe();
    rd(ADDR_DIAG, 16'h0002, "supply high");
    strobe();
    rd(ADDR_DIAG, 16'h0002, "supply high again");
    errIn[1] = 1'b0;
    strobe();
    rd(ADDR_DIAG, 16'h0000, "supply back");
    host_u.xfer(16'h0000, 15, rx);
    rd(ADDR_DIAG, 16'h0008, "short frame");
    rd(ADDR_DIAG, 16'h0000, "short frame cleared");
    // Wake on a matching time and date only while enabled
    inStandby = 1'b1;
    wr(ADDR_TIME, 16'h1015);
    check("timestamp", 16'h1015, timestamp);
    wr(ADDR_DATE, 16'h0415);
    wr(ADDR_WAKE_D, 16'h0415);
    wr(ADDR_WAKE_T, 16'h1015);
    cyc(5);
    check("wake disabled", 16'h0000, {15'h0000, wakeRequest});
    wr(ADDR_WAKE_T, 16'h9015);
    cyc(5);
    check("wake enabled", 16'h0001, {15'h0000, wakeRequest});
    summarize();
  end
endmodule : test_diag_offset_clock_registers
`default_nettype wire
